// File: design/ofd_cycle_div.sv
// four-phase divider giving one enable pulse per instruction cycle
`timescale 1ns/100ps
`default_nettype none
module ofd_cycle_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n_sync,
  // enable out
  output logic cycle_en
);
  logic [1:0] phase_r;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign cycle_en = (phase_r == ofd_pkg::PHASES_LAST);
endmodule
`default_nettype wire

// File: design/ofd_top.sv
// operand field decoder with its operand-side registers
// How it works
// RL1: access bit 0 selects access RAM, 1 lets bank register pick bank.
// RL2: a bank select register chooses the RAM bank for banked accesses.
// RL3: destination bit 0 writes accumulator, 1 writes addressed file register.
// RL4: three-bit field picks bit 0 to 7 of the addressed byte.
// RL5: file field is 8-bit address or 2-bit pointer number for pointer loads.
// RL6: two-word move takes 12-bit source address from first word.
// RL7: two-word move takes 12-bit destination from second word and writes there.
// RL8: literal decodes as 8, 12 or 20 bits depending on format.
// RL9: table mode selects keep, post-increment, post-decrement or pre-increment.
// RL10: branch field is signed relative offset or absolute target address.
// RL11: fast bit 1 saves or restores shadow copies on call or return.
// RL12: a 21-bit table pointer addresses program memory for table accesses.
// RL13: an 8-bit table latch holds the byte a table access moves.
// RL14: don't-care bits are ignored by decoding; generators should emit 0.
// RL15: indexed forms add 7-bit offsets to an indirect pointer.
// RL16: five status flags carry, digit carry, zero, overflow, negative kept.
// RL17: multiply product is split over high and low product registers.
// RL18: high and upper latches supply upper PC bits on low-byte write.
// RL19: second words carry 1111 on top; executed alone they act as no-op.
// RL20: instruction cycle is four clocks; taken test or jump adds no-op cycle.
// RL21: all fields come out combinationally in the cycle the word shows.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ofd_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // fetch side
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire ofd_pkg::ofd_fmt_t instr_fmt,
  input wire logic flush_next,
  output logic cycle_en,
  output logic word_take,
  output logic nop_cycle,
  // decoded fields
  output logic [11:0] ram_addr,
  output logic dest_is_file,
  output logic [2:0] bit_pos,
  output logic [7:0] bit_mask,
  output logic [1:0] ptr_sel,
  output logic [19:0] literal,
  output logic [20:0] rel_offset,
  output logic [19:0] abs_target,
  output logic fast_sel,
  output ofd_pkg::ofd_tbl_t table_access_mode,
  output logic [11:0] move_src,
  output logic [11:0] move_dst,
  output logic move_we,
  output logic [11:0] idx_src_addr,
  output logic [11:0] idx_dst_addr,
  // datapath results
  input wire logic result_valid,
  input wire logic [7:0] result_data,
  output logic file_we,
  output logic accum_we,
  input wire logic [4:0] flag_we,
  input wire logic [4:0] flag_val,
  input wire logic mul_go,
  input wire logic [7:0] file_rdata,
  // table access
  input wire logic tbl_go,
  input wire logic tbl_write,
  input wire logic [7:0] prog_rdata,
  output logic [20:0] prog_addr,
  output logic [7:0] prog_wdata,
  output logic prog_re,
  output logic prog_we,
  // call, return and program counter
  input wire logic call_go,
  input wire logic ret_go,
  input wire logic pcl_write,
  input wire logic [7:0] pcl_data,
  output logic pc_load,
  output logic [20:0] pc_load_addr,
  // visible state
  output logic [7:0] accum_out,
  output logic [4:0] status_out,
  output logic [3:0] bank_out
);
  logic rst_s1_r;
  logic rst_n_sync;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_sync <= rst_s1_r;
    end
  end

  ofd_cycle_div u_div (
    .clk_sys(clk_sys),
    .rst_n_sync(rst_n_sync),
    .cycle_en(cycle_en) // RL20
  );

  // architectural registers
  logic [3:0] bank_select_register;
  logic [7:0] working_accumulator;
  logic [20:0] table_pointer;
  logic [7:0] table_latch;
  logic [7:0] product_high_byte;
  logic [7:0] product_low_byte;
  logic [7:0] pc_high_latch;
  logic [4:0] pc_upper_latch;
  logic [4:0] status_r;
  logic [11:0] indirect_pointer [3];
  logic [7:0] shadow_accum_r;
  logic [4:0] shadow_status_r;
  logic [3:0] shadow_bank_r;

  // two-word sequencing
  ofd_pkg::ofd_seq_t seq_r;
  ofd_pkg::ofd_fmt_t first_fmt_r;
  logic [11:0] first_low_r;
  logic flush_r;
  logic second_tag;
  logic in_second;

  assign word_take = instr_valid && cycle_en;
  assign second_tag = (instr_word[15:12] == ofd_pkg::SECOND_TAG);
  assign in_second = (seq_r == ofd_pkg::ST_SECOND);
  // lone second word or flushed slot executes as no-op
  assign nop_cycle = word_take && (flush_r || (!in_second && second_tag
                     && instr_fmt != ofd_pkg::FMT_MOVE
                     && instr_fmt != ofd_pkg::FMT_ABS)); // RL19 RL20

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      seq_r <= ofd_pkg::ST_SINGLE;
      first_fmt_r <= ofd_pkg::FMT_BYTE;
      first_low_r <= 12'h000;
    end else if (word_take) begin
      case (seq_r)
        ofd_pkg::ST_SINGLE: begin
          if (!flush_r && (instr_fmt == ofd_pkg::FMT_MOVE
              || instr_fmt == ofd_pkg::FMT_ABS
              || instr_fmt == ofd_pkg::FMT_PTRLIT)) begin
            seq_r <= ofd_pkg::ST_SECOND;
            first_fmt_r <= instr_fmt;
            first_low_r <= instr_word[11:0]; // RL6
          end
        end
        ofd_pkg::ST_SECOND: begin
          seq_r <= ofd_pkg::ST_SINGLE;
        end
        default: begin
          seq_r <= ofd_pkg::ST_SINGLE;
        end
      endcase
    end
  end

  // a taken test or jump turns the following fetch slot into a no-op
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flush_r <= 1'b0;
    end else if (flush_next) begin
      flush_r <= 1'b1; // RL20
    end else if (word_take) begin
      flush_r <= 1'b0;
    end
  end

  // field extraction, purely combinational from the presented word; in a second word ptr_sel comes from the stored first word
  // only defined bit positions are looked at, so don't-care bits drop out
  logic [7:0] file_f;
  assign file_f = instr_word[7:0]; // RL14 RL21
  assign dest_is_file = instr_word[ofd_pkg::DEST_BIT];
  assign bit_pos = instr_word[ofd_pkg::BITPOS_LSB +: 3]; // RL4
  assign bit_mask = 8'h01 << bit_pos; // RL4
  assign ptr_sel = in_second ? first_low_r[ofd_pkg::PTRSEL_LSB +: 2]
                             : instr_word[ofd_pkg::PTRSEL_LSB +: 2]; // RL5
  assign fast_sel = instr_word[ofd_pkg::FAST_BIT];
  assign table_access_mode = ofd_pkg::ofd_tbl_t'(instr_word[1:0]); // RL9

  always_comb begin
    if (!instr_word[ofd_pkg::ACC_BIT]) begin
      // access RAM: low half from bank 0, upper half from the top bank
      ram_addr = {(file_f >= ofd_pkg::ACCESS_SPLIT) ? ofd_pkg::ACCESS_HI_BANK
                  : ofd_pkg::ACCESS_LO_BANK, file_f}; // RL1
    end else begin
      ram_addr = {bank_select_register, file_f}; // RL1 RL2 RL5
    end
  end

  always_comb begin
    if (in_second && first_fmt_r == ofd_pkg::FMT_ABS) begin
      literal = {instr_word[11:0], first_low_r[7:0]}; // RL8
    end else if (in_second && first_fmt_r == ofd_pkg::FMT_PTRLIT) begin
      literal = {8'h00, first_low_r[3:0], instr_word[7:0]}; // RL8
    end else begin
      literal = {12'h000, instr_word[7:0]}; // RL8
    end
  end

  always_comb begin
    if (instr_fmt == ofd_pkg::FMT_BRA_LONG) begin
      rel_offset = {{10{instr_word[10]}}, instr_word[10:0]}; // RL10
    end else begin
      rel_offset = {{13{instr_word[7]}}, instr_word[7:0]}; // RL10
    end
  end
  assign abs_target = {instr_word[11:0], first_low_r[7:0]}; // RL10

  assign move_src = first_low_r; // RL6
  assign move_dst = instr_word[11:0]; // RL7
  assign move_we = word_take && in_second && !flush_r
                   && first_fmt_r == ofd_pkg::FMT_MOVE && second_tag; // RL7

  // indexed offsets ride on the third indirect pointer
  assign idx_src_addr = indirect_pointer[ofd_pkg::IDX_PTR]
                        + {5'h00, instr_word[6:0]}; // RL15
  assign idx_dst_addr = indirect_pointer[ofd_pkg::IDX_PTR]
                        + {5'h00, (in_second ? instr_word[6:0]
                                             : first_low_r[6:0])}; // RL15

  assign accum_we = result_valid && !dest_is_file; // RL3
  assign file_we = result_valid && dest_is_file; // RL3

  // register port decode
  logic wr_hit_ptr;
  logic [2:0] ptr_byte;
  assign wr_hit_ptr = reg_addr >= ofd_pkg::REG_PTR_BASE
                      && reg_addr <= ofd_pkg::REG_PTR_LAST;
  assign ptr_byte = 3'(reg_addr - ofd_pkg::REG_PTR_BASE);

  // hardware updates win over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      working_accumulator <= ofd_pkg::RST_BYTE;
    end else if (ret_go && fast_sel) begin
      working_accumulator <= shadow_accum_r; // RL11
    end else if (accum_we) begin
      working_accumulator <= result_data; // RL3
    end else if (reg_wr && reg_addr == ofd_pkg::REG_ACCUM) begin
      working_accumulator <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bank_select_register <= 4'h0;
    end else if (ret_go && fast_sel) begin
      bank_select_register <= shadow_bank_r; // RL11
    end else if (reg_wr && reg_addr == ofd_pkg::REG_BANK) begin
      bank_select_register <= reg_wdata[3:0]; // RL2
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      status_r <= 5'h00;
    end else if (ret_go && fast_sel) begin
      status_r <= shadow_status_r; // RL11
    end else if (flag_we != 5'h00) begin
      status_r <= (status_r & ~flag_we) | (flag_val & flag_we); // RL16
    end else if (reg_wr && reg_addr == ofd_pkg::REG_STATUS) begin
      status_r <= reg_wdata[4:0];
    end
  end

  // shadow copies for fast call
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      shadow_accum_r <= ofd_pkg::RST_BYTE;
      shadow_status_r <= 5'h00;
      shadow_bank_r <= 4'h0;
    end else if (call_go && fast_sel) begin
      shadow_accum_r <= working_accumulator; // RL11
      shadow_status_r <= status_r;
      shadow_bank_r <= bank_select_register;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      product_high_byte <= ofd_pkg::RST_BYTE;
      product_low_byte <= ofd_pkg::RST_BYTE;
    end else if (mul_go) begin
      {product_high_byte, product_low_byte} <=
        working_accumulator * file_rdata; // RL17
    end else if (reg_wr && reg_addr == ofd_pkg::REG_PROD_L) begin
      product_low_byte <= reg_wdata;
    end else if (reg_wr && reg_addr == ofd_pkg::REG_PROD_H) begin
      product_high_byte <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pc_high_latch <= ofd_pkg::RST_BYTE;
      pc_upper_latch <= 5'h00;
    end else if (reg_wr && reg_addr == ofd_pkg::REG_PCLAT_H) begin
      pc_high_latch <= reg_wdata; // RL18
    end else if (reg_wr && reg_addr == ofd_pkg::REG_PCLAT_U) begin
      pc_upper_latch <= reg_wdata[4:0]; // RL18
    end
  end

  // low-byte write jumps using both latches as the upper bits
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pc_load <= 1'b0;
      pc_load_addr <= 21'h000000;
    end else begin
      pc_load <= pcl_write;
      if (pcl_write) begin
        pc_load_addr <= {pc_upper_latch, pc_high_latch, pcl_data}; // RL18
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      for (int i = 0; i < 3; i++) begin
        indirect_pointer[i] <= 12'h000;
      end
    end else if (word_take && in_second && !flush_r
                 && first_fmt_r == ofd_pkg::FMT_PTRLIT) begin
      indirect_pointer[ptr_sel] <= literal[11:0]; // RL5 RL8
    end else if (reg_wr && wr_hit_ptr) begin
      if (ptr_byte[0]) begin
        indirect_pointer[ptr_byte[2:1]][11:8] <= reg_wdata[3:0];
      end else begin
        indirect_pointer[ptr_byte[2:1]][7:0] <= reg_wdata;
      end
    end
  end

  // table access: pointer step, program memory strobe, latch
  ofd_pkg::ofd_tbl_t tmode;
  logic [20:0] tptr_inc;
  logic [20:0] tptr_dec;
  logic tbl_rd_pend_r;
  assign tmode = table_access_mode;
  assign tptr_inc = table_pointer + 21'h000001;
  assign tptr_dec = table_pointer - 21'h000001;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      table_pointer <= 21'h000000;
    end else if (tbl_go) begin
      case (tmode)
        ofd_pkg::TBL_POST_INC: table_pointer <= tptr_inc; // RL9
        ofd_pkg::TBL_POST_DEC: table_pointer <= tptr_dec; // RL9
        ofd_pkg::TBL_PRE_INC: table_pointer <= tptr_inc; // RL9
        default: table_pointer <= table_pointer; // RL9
      endcase
    end else if (reg_wr && reg_addr == ofd_pkg::REG_TPTR_L) begin
      table_pointer[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == ofd_pkg::REG_TPTR_H) begin
      table_pointer[15:8] <= reg_wdata;
    end else if (reg_wr && reg_addr == ofd_pkg::REG_TPTR_U) begin
      table_pointer[20:16] <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      prog_addr <= 21'h000000;
      prog_wdata <= ofd_pkg::RST_BYTE;
      prog_re <= 1'b0;
      prog_we <= 1'b0;
    end else begin
      prog_re <= tbl_go && !tbl_write;
      prog_we <= tbl_go && tbl_write;
      if (tbl_go) begin
        prog_addr <= (tmode == ofd_pkg::TBL_PRE_INC) ? tptr_inc
                                                     : table_pointer; // RL12
        prog_wdata <= table_latch; // RL13
      end
    end
  end

  // read data are taken the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tbl_rd_pend_r <= 1'b0;
      table_latch <= ofd_pkg::RST_BYTE;
    end else begin
      tbl_rd_pend_r <= prog_re;
      if (tbl_rd_pend_r) begin
        table_latch <= prog_rdata; // RL13
      end else if (reg_wr && reg_addr == ofd_pkg::REG_TLATCH) begin
        table_latch <= reg_wdata; // RL13
      end
    end
  end

  // read port: one cycle latency, unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata <= ofd_pkg::RST_BYTE;
    end else if (reg_rd) begin
      if (reg_addr == ofd_pkg::REG_BANK) begin
        reg_rdata <= {4'h0, bank_select_register};
      end else if (reg_addr == ofd_pkg::REG_ACCUM) begin
        reg_rdata <= working_accumulator;
      end else if (reg_addr == ofd_pkg::REG_TPTR_L) begin
        reg_rdata <= table_pointer[7:0];
      end else if (reg_addr == ofd_pkg::REG_TPTR_H) begin
        reg_rdata <= table_pointer[15:8];
      end else if (reg_addr == ofd_pkg::REG_TPTR_U) begin
        reg_rdata <= {3'h0, table_pointer[20:16]};
      end else if (reg_addr == ofd_pkg::REG_TLATCH) begin
        reg_rdata <= table_latch;
      end else if (reg_addr == ofd_pkg::REG_PROD_L) begin
        reg_rdata <= product_low_byte;
      end else if (reg_addr == ofd_pkg::REG_PROD_H) begin
        reg_rdata <= product_high_byte;
      end else if (reg_addr == ofd_pkg::REG_PCLAT_H) begin
        reg_rdata <= pc_high_latch;
      end else if (reg_addr == ofd_pkg::REG_PCLAT_U) begin
        reg_rdata <= {3'h0, pc_upper_latch};
      end else if (reg_addr == ofd_pkg::REG_STATUS) begin
        reg_rdata <= {3'h0, status_r}; // RL16
      end else if (wr_hit_ptr && ptr_byte[0]) begin
        reg_rdata <= {4'h0, indirect_pointer[ptr_byte[2:1]][11:8]};
      end else if (wr_hit_ptr) begin
        reg_rdata <= indirect_pointer[ptr_byte[2:1]][7:0];
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign accum_out = working_accumulator;
  assign status_out = status_r;
  assign bank_out = bank_select_register;
endmodule
`default_nettype wire

// File: pkg/ofd_pkg.sv
// shared constants and types for the operand field decoder
package ofd_pkg;
  // register port offsets
  localparam logic [7:0] REG_BANK = 8'h00;
  localparam logic [7:0] REG_ACCUM = 8'h01;
  localparam logic [7:0] REG_TPTR_L = 8'h02;
  localparam logic [7:0] REG_TPTR_H = 8'h03;
  localparam logic [7:0] REG_TPTR_U = 8'h04;
  localparam logic [7:0] REG_TLATCH = 8'h05;
  localparam logic [7:0] REG_PROD_L = 8'h06;
  localparam logic [7:0] REG_PROD_H = 8'h07;
  localparam logic [7:0] REG_PCLAT_H = 8'h08;
  localparam logic [7:0] REG_PCLAT_U = 8'h09;
  localparam logic [7:0] REG_STATUS = 8'h0A;
  localparam logic [7:0] REG_PTR_BASE = 8'h0B;
  localparam logic [7:0] REG_PTR_LAST = 8'h10;
  // instruction word field positions
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam int BITPOS_LSB = 9;
  localparam int PTRSEL_LSB = 4;
  localparam int FAST_BIT = 0;
  localparam logic [3:0] SECOND_TAG = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [1:0] IDX_PTR = 2'h2;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  // timing
  localparam logic [1:0] PHASES_LAST = 2'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // operand format announced by the core opcode decoder
  typedef enum logic [3:0] {
    FMT_BYTE, FMT_BIT, FMT_LIT8, FMT_PTRLIT, FMT_MOVE, FMT_ABS,
    FMT_BRA_LONG, FMT_BRA_SHORT, FMT_TABLE, FMT_INDEX
  } ofd_fmt_t;
  // table pointer behaviour
  typedef enum logic [1:0] {
    TBL_KEEP, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC
  } ofd_tbl_t;
  typedef enum logic {ST_SINGLE, ST_SECOND} ofd_seq_t;
endpackage

// File: testbench/ofd_fetch_model.sv
// fetch path and program memory model facing the decoder
`timescale 1ns/100ps
`default_nettype none
module ofd_fetch_model (
  // clock
  input wire logic clk_sys,
  // fetch handshake
  input wire logic word_take,
  output logic [15:0] instr_word,
  output logic instr_valid,
  output ofd_pkg::ofd_fmt_t instr_fmt,
  // program memory
  input wire logic prog_re,
  input wire logic [20:0] prog_addr,
  output logic [7:0] prog_rdata
);
  // entries are {format, word}, pushed by the bench
  logic [19:0] q[$];
  initial begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    instr_fmt = ofd_pkg::FMT_BYTE;
    prog_rdata = 8'h00;
  end
  always @(posedge clk_sys) begin
    if (word_take && q.size() > 0)
      void'(q.pop_front());
    if (q.size() > 0) begin
      instr_valid <= 1'b1;
      instr_word <= q[0][15:0];
      instr_fmt <= ofd_pkg::ofd_fmt_t'(q[0][19:16]);
    end else begin
      // idle word toggles so stale values show
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
    prog_rdata <= prog_re ? (prog_addr[7:0] ^ 8'hA5) : ~prog_rdata;
  end
endmodule
`default_nettype wire

// File: testbench/ofd_top_props.sv
// port-level property checker for the operand field decoder
`timescale 1ns/100ps
`default_nettype none
module ofd_top_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // fetch and decode
  input wire logic [15:0] instr_word,
  input wire ofd_pkg::ofd_fmt_t instr_fmt,
  input wire logic cycle_en,
  input wire logic word_take,
  input wire logic [11:0] ram_addr,
  input wire logic [3:0] bank_out,
  input wire logic [7:0] bit_mask,
  input wire logic [20:0] rel_offset,
  input wire logic [11:0] move_dst,
  input wire logic move_we,
  // results, table and program counter
  input wire logic result_valid,
  input wire logic file_we,
  input wire logic accum_we,
  input wire logic tbl_go,
  input wire logic tbl_write,
  input wire logic prog_re,
  input wire logic prog_we,
  input wire logic pcl_write,
  input wire logic [7:0] pcl_data,
  input wire logic pc_load,
  input wire logic [20:0] pc_load_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_access_low:
  assert property (!instr_word[8] |-> ram_addr ==
    {(instr_word[7] ? 4'hF : 4'h0), instr_word[7:0]})
    else $error("access ram address wrong");
  a_bank_pick:
  assert property (instr_word[8] |-> ram_addr == {bank_out, instr_word[7:0]})
    else $error("banked address wrong");
  a_dest_route:
  assert property (result_valid |->
    file_we == instr_word[9] && accum_we == !instr_word[9])
    else $error("result routed wrong");
  a_bit_mask:
  assert property (word_take |-> bit_mask == 8'h01 << instr_word[11:9])
    else $error("bit mask wrong");
  a_long_offset:
  assert property (instr_fmt == ofd_pkg::FMT_BRA_LONG |->
    rel_offset == {{10{instr_word[10]}}, instr_word[10:0]})
    else $error("long offset not sign extended");
  a_take_cadence:
  assert property (word_take |=> !cycle_en [*3] ##1 cycle_en)
    else $error("instruction cycle not four clocks");
  a_table_strobe:
  assert property (tbl_go |=>
    prog_re == !$past(tbl_write) && prog_we == $past(tbl_write))
    else $error("table strobe wrong");
  a_move_second:
  assert property (move_we |-> word_take && instr_word[15:12] == 4'hF
    && move_dst == instr_word[11:0])
    else $error("move write outside tagged second word");
  a_pc_load:
  assert property (pcl_write |=> pc_load && pc_load_addr[7:0] == $past(pcl_data))
    else $error("pc load missing");
endmodule
`default_nettype wire

// File: testbench/operand_field_decoder_test.sv
// self-checking bench for the operand field decoder
`timescale 1ns/100ps
`default_nettype none
module operand_field_decoder_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, flush_next = 1'b0, tbl_go = 1'b0;
  logic ret_go = 1'b0, call_go = 1'b0, result_valid = 1'b0, mul_go = 1'b0;
  logic tbl_write = 1'b0, pcl_write = 1'b0;
  logic [7:0] result_data = 8'h00, file_rdata = 8'h00, pcl_data = 8'h00;
  logic [4:0] flag_we = 5'h00, flag_val = 5'h00;
  logic [15:0] instr_word;
  logic instr_valid, cycle_en, word_take, nop_cycle, move_we, fast_sel;
  logic dest_is_file, file_we, accum_we, prog_re, prog_we, pc_load;
  ofd_pkg::ofd_fmt_t instr_fmt;
  ofd_pkg::ofd_tbl_t table_access_mode;
  logic [11:0] ram_addr, move_src, move_dst, idx_src_addr;
  logic [7:0] bit_mask, prog_rdata;
  logic [19:0] literal, abs_target;
  logic [20:0] rel_offset, prog_addr, pc_load_addr;
  logic [31:0] v, p, w, e;
  logic [3:0] f;
  int n_fail = 0, tests_run = 0, seed = 73, cyc = 0, bank, st;
  always #20 clk_sys = ~clk_sys;
  ofd_top dut (.*, .bit_pos(), .ptr_sel(), .idx_dst_addr(), .prog_wdata(),
    .accum_out(), .status_out(), .bank_out());
  ofd_fetch_model pm (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = {24'h0, reg_rdata};
  endtask
  // word enters at phase 0 so one-cycle side pulses land while it shows
  task feed(input logic [19:0] ent, input logic [3:0] g);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cycle_en !== 1'b1)
      @(negedge clk_sys);
    pm.q.push_back(ent);
    @(posedge clk_sys);
    {flush_next, tbl_go, ret_go, call_go} <= g;
    @(posedge clk_sys);
    {flush_next, tbl_go, ret_go, call_go} <= 4'h0;
    @(negedge clk_sys);
    while (word_take !== 1'b1 && n < 8) begin
      n++;
      @(negedge clk_sys);
    end
    chk(word_take, 1'b1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(8'h20, 8'hAA);
    for (int a = 0; a <= 32; a++) begin
      rd(a[7:0], v);
      chk(v, 0);
    end
    bank = $random(seed) & 15;
    wr(ofd_pkg::REG_BANK, bank[7:0]);
    result_valid <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      f = (i % 4 == 3) ? 4'h6 : 4'(i % 4);
      result_data <= w[31:24];
      feed({f, w[15:0]}, 4'h0);
      p = w[8] ? {bank[3:0], w[7:0]} : {(w[7] ? 4'hF : 4'h0), w[7:0]};
      chk(ram_addr, p);
      chk(dest_is_file, w[9]);
      chk(accum_we, !w[9]);
      chk(bit_mask, 32'h1 << w[11:9]);
      chk(literal, w[7:0]);
      chk(table_access_mode, w[1:0]);
      chk(fast_sel, w[0]);
      chk(nop_cycle, w[15:12] == 4'hF);
      if (f == 4'h6)
        chk(rel_offset, {{10{w[10]}}, w[10:0]});
    end
    result_valid <= 1'b0;
    e = $random(seed);
    feed({4'h4, 4'hC, e[11:0]}, 4'h0);
    feed({4'h0, 4'hF, e[27:16]}, 4'h0);
    chk(move_we, 1'b1);
    chk(move_src, e[11:0]);
    chk(move_dst, e[27:16]);
    feed({4'h5, 8'hEF, e[7:0]}, 4'h0);
    feed({4'h0, 4'hF, e[19:8]}, 4'h0);
    chk(literal, e[19:0]);
    chk(abs_target, e[19:0]);
    chk(nop_cycle, 1'b0);
    feed({4'h0, 4'hF, e[11:0]}, 4'h0);
    chk(nop_cycle, 1'b1);
    chk(move_we, 1'b0);
    feed({8'h20, e[11:0]}, 4'h8);
    chk(nop_cycle, 1'b1);
    st = 0;
    for (int i = 0; i < 3; i++) begin
      e = $random(seed);
      @(posedge clk_sys);
      flag_we <= e[4:0];
      flag_val <= e[12:8];
      @(posedge clk_sys);
      flag_we <= 5'h00;
      st = (st & ~e[4:0]) | (e[12:8] & e[4:0]);
      rd(ofd_pkg::REG_STATUS, v);
      chk(v, st & 31);
    end
    e = $random(seed);
    wr(ofd_pkg::REG_ACCUM, e[7:0]);
    file_rdata <= e[15:8];
    @(posedge clk_sys);
    mul_go <= 1'b1;
    @(posedge clk_sys);
    mul_go <= 1'b0;
    p = e[7:0] * e[15:8];
    rd(ofd_pkg::REG_PROD_L, v);
    chk(v, p[7:0]);
    rd(ofd_pkg::REG_PROD_H, v);
    chk(v, p[15:8]);
    wr(ofd_pkg::REG_ACCUM, 8'h5A);
    feed(20'h20001, 4'h1);
    wr(ofd_pkg::REG_ACCUM, 8'hC3);
    feed(20'h20001, 4'h2);
    rd(ofd_pkg::REG_ACCUM, v);
    chk(v, 8'h5A);
    wr(ofd_pkg::REG_ACCUM, 8'h3C);
    feed(20'h20000, 4'h2);
    rd(ofd_pkg::REG_ACCUM, v);
    chk(v, 8'h3C);
    // start at the top so post-inc and pre-inc both wrap
    p = 32'h1FFFFF;
    wr(ofd_pkg::REG_TPTR_L, 8'hFF);
    wr(ofd_pkg::REG_TPTR_H, 8'hFF);
    wr(ofd_pkg::REG_TPTR_U, 8'h1F);
    for (int m = 0; m < 4; m++) begin
      e = ((m == 3) ? p + 1 : p) & 32'h1FFFFF;
      feed({4'h8, 14'h0, m[1:0]}, 4'h4);
      p = (m == 2) ? p - 1 : (m[0] ? p + 1 : p);
      p = p & 32'h1FFFFF;
      rd(ofd_pkg::REG_TLATCH, v);
      chk(v, e[7:0] ^ 8'hA5);
      rd(ofd_pkg::REG_TPTR_L, w);
      rd(ofd_pkg::REG_TPTR_H, v);
      w = w | (v << 8);
      rd(ofd_pkg::REG_TPTR_U, v);
      chk(w | (v << 16), p);
    end
    tbl_write <= 1'b1;
    feed(20'h80000, 4'h4);
    tbl_write <= 1'b0;
    e = $random(seed);
    wr(ofd_pkg::REG_PTR_LAST - 8'h01, e[7:0]);
    wr(ofd_pkg::REG_PTR_LAST, {4'h0, e[11:8]});
    feed({4'h9, e[31:16]}, 4'h0);
    chk(idx_src_addr, (e[11:0] + e[22:16]) & 12'hFFF);
    wr(ofd_pkg::REG_PCLAT_H, e[15:8]);
    wr(ofd_pkg::REG_PCLAT_U, e[23:16]);
    @(posedge clk_sys);
    pcl_write <= 1'b1;
    pcl_data <= e[7:0];
    @(posedge clk_sys);
    pcl_write <= 1'b0;
    @(negedge clk_sys);
    chk(pc_load, 1'b1);
    chk(pc_load_addr, e[20:0]);
    close_out;
  end
endmodule
bind ofd_top ofd_top_props u_props (.*);
`default_nettype wire
